//--- verif/tb_top.sv
// Purpose: Self-checking bench of the compare unit
// Assumes: Timer model on the far side; sleep raised in one scenario
// Notes:   Outputs are read right after an edge, before it lands
`timescale 1ns/1ns
module tb_top;
    logic        clk_i, reset_i, avs_read, avs_write, avs_waitrequest_o;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata_o, rd;
    logic [15:0] count, load_val;
    logic        tick, ovf, run, load, sleep, timer_reset_o, adc_start_o;
    logic        pin_out_o, pin_oe_o, irq_o;
    logic [7:0]  conv;
    int          failures, comparisons, cycles, n_adc, n_trst;

    tcu_compare DUT (.clk_i(clk_i), .reset_i(reset_i),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_byteenable_i(4'hf),
        .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .timer_count_i(count),
        .timer_tick_i(tick), .sleep_i(sleep), .timer_reset_o(timer_reset_o),
        .adc_start_o(adc_start_o), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .irq_o(irq_o));
    tcu_timer_model u_timer (.clk_i(clk_i), .reset_i(reset_i), .run_i(run),
        .load_i(load), .load_val_i(load_val), .treset_i(timer_reset_o),
        .adc_go_i(adc_start_o), .count_o(count), .tick_o(tick),
        .ovf_o(ovf), .conv_o(conv));

    // ****************************************
    // Clock, pulse counters and watchdog
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (adc_start_o === 1'b1) n_adc++;
        if (timer_reset_o === 1'b1) n_trst++;
        if (cycles == 20000) begin // Hang guard
            failures++;
            give_verdict();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // One Avalon access; held until waitrequest is seen low
    // No cycle limit here: only the hang guard ends a stuck wait
    task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task rdchk(input string what, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        check(what, e, rd);
    endtask : rdchk
    // Fresh match: compare leaves, then returns to count 0x1234
    task match_now;
        bus(1'b1, tcu_pkg::OFF_CMP_HI, 8'h00);
        bus(1'b1, tcu_pkg::OFF_CMP_HI, 8'h12);
        repeat (3) @(posedge clk_i);
    endtask : match_now
    task stage;
        @(posedge clk_i);
        load_val <= 16'h1234;
        load     <= 1'b1;
        @(posedge clk_i);
        load     <= 1'b0;
    endtask : stage
    task give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        logic [4:0] adr [7];
        adr = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14, 5'h18, 5'h1c};
        check("waitrequest idle", 32'h1, avs_waitrequest_o);
        foreach (adr[i]) rdchk("reset value", adr[i], 32'h0);
        check("pin_oe reset", 32'h0, pin_oe_o);
        $display("test reset done");
    endtask : t_reset
    task t_pin_modes;
        bus(1'b1, tcu_pkg::OFF_CMP_LO, 8'h34);
        // Pin taken as already set to output by software
        bus(1'b1, tcu_pkg::OFF_CONTROL, {4'h0, tcu_pkg::MODE_SET});
        match_now();
        check("set pin", 32'h1, pin_out_o);
        check("set oe", 32'h1, pin_oe_o);
        rdchk("match flag", tcu_pkg::OFF_STATUS, 32'h1);
        bus(1'b1, tcu_pkg::OFF_CLEAR, 8'h07);
        bus(1'b1, tcu_pkg::OFF_CONTROL, {4'h0, tcu_pkg::MODE_CLEAR});
        match_now();
        check("clear pin", 32'h0, pin_out_o);
        bus(1'b1, tcu_pkg::OFF_CONTROL, {4'h0, tcu_pkg::MODE_TOGGLE});
        match_now();
        repeat (8) @(posedge clk_i);
        check("toggle once", 32'h1, pin_out_o);
        rdchk("live state", tcu_pkg::OFF_STATE, 32'h3);
        bus(1'b1, tcu_pkg::OFF_CONTROL, 8'h00);
        repeat (2) @(posedge clk_i);
        check("zero control", 32'h0, pin_out_o);
        $display("test pin modes done");
    endtask : t_pin_modes
    task t_swint;
        bus(1'b1, tcu_pkg::OFF_CLEAR, 8'h07);
        bus(1'b1, tcu_pkg::OFF_CONTROL, {4'h0, tcu_pkg::MODE_SWINT});
        bus(1'b1, tcu_pkg::OFF_ENABLE, 8'h01);
        match_now();
        check("swint oe", 32'h0, pin_oe_o);
        check("swint irq", 32'h1, irq_o);
        check("swint trigger", 32'h0, n_adc);
        bus(1'b1, tcu_pkg::OFF_ENABLE, 8'h00);
        repeat (2) @(posedge clk_i);
        check("masked irq", 32'h0, irq_o);
        bus(1'b1, tcu_pkg::OFF_ENABLE, 8'h01);
        bus(1'b1, tcu_pkg::OFF_CLEAR, 8'h01);
        repeat (2) @(posedge clk_i);
        check("cleared irq", 32'h0, irq_o);
        bus(1'b1, tcu_pkg::OFF_CLEAR, 8'h07);
        sleep <= 1'b1;
        match_now();
        rdchk("asleep flag", tcu_pkg::OFF_STATUS, 32'h0);
        sleep <= 1'b0;
        $display("test software interrupt done");
    endtask : t_swint
    task t_special;
        bus(1'b1, tcu_pkg::OFF_CONTROL, {4'h0, tcu_pkg::MODE_SPECIAL});
        match_now();
        check("trigger now", 32'h1, n_adc);
        check("no reset yet", 32'h0, n_trst);
        check("conversion", 32'h1, conv);
        check("special oe", 32'h0, pin_oe_o);
        run <= 1'b1;
        repeat (12) @(posedge clk_i);
        run <= 1'b0;
        check("timer reset", 32'h1, n_trst);
        check("timer cleared", 32'h0, count[15:4]);
        check("no overflow", 32'h0, ovf);
        rdchk("status all", tcu_pkg::OFF_STATUS, 32'h7);
        $display("test special trigger done");
    endtask : t_special
    task t_cancel;
        // Move compare away first, so loading the count makes no match
        bus(1'b1, tcu_pkg::OFF_CMP_HI, 8'h00);
        stage();
        bus(1'b1, tcu_pkg::OFF_CLEAR, 8'h07);
        match_now();
        // Compare parked far from any count the timer reaches here
        bus(1'b1, tcu_pkg::OFF_CMP_LO, 8'h00);
        run <= 1'b1;
        repeat (12) @(posedge clk_i);
        run <= 1'b0;
        check("second trigger", 32'h2, n_adc);
        check("reset cancelled", 32'h1, n_trst);
        check("timer kept", 32'h123, count[15:4]);
        $display("test cancel done");
    endtask : t_cancel

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_i = 1'b1;
        {avs_read, avs_write, run, load, sleep} = 5'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        load_val = 16'h0000;
        {failures, comparisons, cycles, n_adc, n_trst} = '0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        stage();
        t_pin_modes();
        t_swint();
        t_special();
        t_cancel();
        give_verdict();
    end
endmodule : tb_top

//--- verif/tcu_timer_model.sv
// Purpose: Sixteen-bit timer and converter standing beside the unit
// Assumes: One clock; the timer clock edge is a one-cycle enable
// Notes:   Count holds while run_i is low, so tests can stage matches
`timescale 1ns/1ns
module tcu_timer_model #(
    parameter logic ADC_ON = 1'b1           // Converter enabled
) (
    input  wire logic        clk_i,         // System clock
    input  wire logic        reset_i,       // Synchronous reset
    input  wire logic        run_i,         // Timer enable
    input  wire logic        load_i,        // Load count pulse
    input  wire logic [15:0] load_val_i,    // Value to load
    input  wire logic        treset_i,      // Timer reset from the unit
    input  wire logic        adc_go_i,      // Conversion start
    output logic [15:0]      count_o,       // Timer count
    output logic             tick_o,        // Timer clock rising edge
    output logic             ovf_o,         // timer_overflow_flag
    output logic [7:0]       conv_o         // Conversions started
);
    logic [1:0] div_reg;                    // Prescale by four

    // ****************************************
    // Timer clock
    // ****************************************
    // Quarter rate; never every clock, else a pending timer reset is always cancelled
    always_ff @(posedge clk_i) begin
        if (reset_i || !run_i) begin
            div_reg <= 2'h0;
            tick_o  <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            tick_o  <= (div_reg == 2'h3);
        end
    end

    // ****************************************
    // Count and overflow
    // ****************************************
    // Synchronous counter; only a wrap raises the overflow flag
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_o <= 16'h0000;
            ovf_o   <= 1'b0;
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (treset_i) begin
            count_o <= 16'h0000;
        end else if (tick_o) begin
            count_o <= count_o + 16'h0001;
            if (count_o == 16'hffff) begin
                ovf_o <= 1'b1;
            end
        end
    end

    // Converter only counts starts while enabled
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conv_o <= 8'h00;
        end else if (adc_go_i && ADC_ON) begin
            conv_o <= conv_o + 8'h01;
        end
    end
endmodule : tcu_timer_model

//--- verilog/tcu_compare.sv
// Purpose: Compare function of a capture/compare unit on Avalon-MM
// Assumes: Timer count and tick are synchronous to clk_i
// Notes:   One answer cycle per bus access; status is sticky
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns

module tcu_compare (
    input  wire logic        clk_i,           // System clock
    input  wire logic        reset_i,         // Synchronous reset
    input  wire logic [4:0]  avs_address_i,   // Byte address
    input  wire logic        avs_read_i,      // Read request
    input  wire logic        avs_write_i,     // Write request
    input  wire logic [3:0]  avs_byteenable_i, // Byte lanes
    input  wire logic [31:0] avs_writedata_i, // Write data
    output logic [31:0]      avs_readdata_o,  // Read data
    output logic             avs_waitrequest_o, // Stall
    input  wire logic [15:0] timer_count_i,   // Timer high:low bytes
    input  wire logic        timer_tick_i,    // Timer clock rising edge
    input  wire logic        sleep_i,         // System clock halted
    output logic             timer_reset_o,   // Reset timer pulse
    output logic             adc_start_o,     // Special event trigger
    output logic             pin_out_o,       // unit_pin level
    output logic             pin_oe_o,        // Unit drives unit_pin
    output logic             irq_o            // Level interrupt
);

    // ****************************************
    // Declarations
    // ****************************************
    tcu_pkg::tcu_bus_req_s req;               // Packed bus request
    logic [7:0]            ctrl_reg;          // unit_control
    logic [7:0]            cmp_lo_reg;        // compare_value_low
    logic [7:0]            cmp_hi_reg;        // compare_value_high
    logic [2:0]            enable_reg;        // Interrupt enables
    logic [2:0]            flags;             // Sticky status
    logic [2:0]            flag_set;          // Event pulses
    logic [2:0]            flag_clr;          // Clear pulses
    logic                  wait_reg;          // Waitrequest flop
    logic [31:0]           rdata_reg;         // Read data flop
    logic                  accept;            // Access completes now
    logic                  wr_accept;         // Write takes effect
    logic                  match_cur;         // Equal this cycle
    logic                  match_prev_reg;    // Equal last cycle
    logic                  match_evt;         // New match event
    logic                  latch_reg;         // Compare output latch
    logic                  pend_reg;          // Timer reset pending
    logic                  trig_reg;          // Trigger output flop
    logic                  treset_reg;        // Timer reset flop
    logic                  oe_reg;            // Pin drive flop
    logic                  irq_reg;           // Interrupt flop
    logic                  zero_ctrl_wr;      // Zero written to control
    tcu_pkg::tcu_mode_e    mode;              // Decoded mode field

    // ****************************************
    // Bus slave
    // ****************************************
    assign req.read      = avs_read_i;
    assign req.write     = avs_write_i;
    assign req.address   = avs_address_i;
    assign req.byteen    = avs_byteenable_i;
    assign req.writedata = avs_writedata_i;

    // Completes on the cycle after the request is first seen
    assign accept    = (req.read || req.write) && !wait_reg;
    assign wr_accept = accept && req.write && req.byteen[0];

    // Waitrequest is high by default, dropped for one answer cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((req.read || req.write) && wait_reg);
        end
    end

    // Read data prepared in the wait cycle; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req.read && wait_reg) begin
            if (req.address == tcu_pkg::OFF_CONTROL) begin
                rdata_reg <= {24'h00_0000, ctrl_reg};
            end else if (req.address == tcu_pkg::OFF_CMP_LO) begin
                rdata_reg <= {24'h00_0000, cmp_lo_reg};
            end else if (req.address == tcu_pkg::OFF_CMP_HI) begin
                rdata_reg <= {24'h00_0000, cmp_hi_reg};
            end else if (req.address == tcu_pkg::OFF_STATUS) begin
                rdata_reg <= {29'h0000_0000, flags};
            end else if (req.address == tcu_pkg::OFF_ENABLE) begin
                rdata_reg <= {29'h0000_0000, enable_reg};
            end else if (req.address == tcu_pkg::OFF_STATE) begin
                rdata_reg <= {29'h0000_0000, pend_reg, match_cur,
                              latch_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Control and compare registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg   <= tcu_pkg::CONTROL_RST;
            cmp_lo_reg <= tcu_pkg::CMP_RST;
            cmp_hi_reg <= tcu_pkg::CMP_RST;
            enable_reg <= tcu_pkg::ENABLE_RST;
        end else if (wr_accept) begin
            if (req.address == tcu_pkg::OFF_CONTROL) begin
                ctrl_reg <= req.writedata[7:0];
            end else if (req.address == tcu_pkg::OFF_CMP_LO) begin
                cmp_lo_reg <= req.writedata[7:0];
            end else if (req.address == tcu_pkg::OFF_CMP_HI) begin
                cmp_hi_reg <= req.writedata[7:0];
            end else if (req.address == tcu_pkg::OFF_ENABLE) begin
                enable_reg <= req.writedata[2:0];
            end
        end
    end

    assign zero_ctrl_wr = wr_accept && (req.address == tcu_pkg::OFF_CONTROL)
                          && (req.writedata[7:0] == 8'h00);
    assign flag_clr = (wr_accept && (req.address == tcu_pkg::OFF_CLEAR))
                      ? req.writedata[2:0] : 3'h0;

    // ****************************************
    // Comparator
    // ****************************************
    // Only the low nibble selects the mode; upper bits are stored only
    assign mode = tcu_pkg::tcu_mode_e'(ctrl_reg[tcu_pkg::MODE_LSB +: 4]);

    // Timer must be a synchronous source; no resampling here
    // Tick marks instruction or external clock edges
    assign match_cur = ({cmp_hi_reg, cmp_lo_reg} == timer_count_i)
                       && !sleep_i
                       && (mode != tcu_pkg::MODE_OFF);
    // Rising edge of equality, so a held match acts once
    assign match_evt = match_cur && !match_prev_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            match_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_cur;
        end
    end

    // ****************************************
    // Output latch and pin
    // ****************************************
    // Zero control write wins; port data latch is elsewhere
    always_ff @(posedge clk_i) begin
        if (reset_i || zero_ctrl_wr) begin
            latch_reg <= 1'b0;
        end else if (match_evt) begin
            case (mode)
                tcu_pkg::MODE_TOGGLE: latch_reg <= !latch_reg;
                tcu_pkg::MODE_SET:    latch_reg <= 1'b1;
                tcu_pkg::MODE_CLEAR:  latch_reg <= 1'b0;
                default:              latch_reg <= latch_reg;
            endcase
        end
    end

    // Drive only in latch modes; direction bit is software's
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= (mode == tcu_pkg::MODE_TOGGLE)
                      || (mode == tcu_pkg::MODE_SET)
                      || (mode == tcu_pkg::MODE_CLEAR);
        end
    end

    // ****************************************
    // Special event trigger
    // ****************************************
    // Trigger on the match, timer reset waits for the tick
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= match_evt && (mode == tcu_pkg::MODE_SPECIAL);
        end
    end

    // Pending reset dropped when the match vanishes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_reg   <= 1'b0;
            treset_reg <= 1'b0;
        end else begin
            treset_reg <= 1'b0;
            if (match_evt && (mode == tcu_pkg::MODE_SPECIAL)) begin
                pend_reg <= 1'b1;
            end else if (pend_reg && !match_cur) begin
                pend_reg <= 1'b0;
            end else if (pend_reg && timer_tick_i) begin
                pend_reg   <= 1'b0;
                treset_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    // Match flag set with the latch action in every mode except MODE_OFF
    assign flag_set[tcu_pkg::FLG_MATCH]   = match_evt;
    assign flag_set[tcu_pkg::FLG_TRIGGER] = trig_reg;
    assign flag_set[tcu_pkg::FLG_TRESET]  = treset_reg;

    for (genvar g = 0; g < tcu_pkg::FLAG_N; g++) begin : g_flag
        tcu_sticky_flag u_flag (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .set_i   (flag_set[g]),
            .clr_i   (flag_clr[g]),
            .flag_o  (flags[g])
        );
    end

    // Level output, one cycle behind the status bits
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags & enable_reg);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Timer reset is its own strobe, apart from overflow
    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign timer_reset_o     = treset_reg;
    assign adc_start_o       = trig_reg;
    assign pin_out_o         = latch_reg;
    assign pin_oe_o          = oe_reg;
    assign irq_o             = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_match_sets_flag: assert property (match_evt |=> flags[0])
        else $error("match did not set interrupt flag");
    a_compare_equal: assert property (
        ({cmp_hi_reg, cmp_lo_reg} == timer_count_i) && !sleep_i
        && mode != tcu_pkg::MODE_OFF
        |=> flags[tcu_pkg::FLG_MATCH] || $past(match_prev_reg))
        else $error("equal count gave no match event");
    a_toggle_flips: assert property (
        match_evt && mode == tcu_pkg::MODE_TOGGLE && !zero_ctrl_wr
        |=> pin_out_o != $past(pin_out_o))
        else $error("toggle mode did not flip latch");
    a_set_drives: assert property (
        match_evt && mode == tcu_pkg::MODE_SET && !zero_ctrl_wr
        |=> pin_out_o ##1 pin_oe_o)
        else $error("set mode did not raise pin");
    a_zero_clears: assert property (zero_ctrl_wr |=> !pin_out_o)
        else $error("zero control write left latch high");
    a_swint_no_pin: assert property (
        mode == tcu_pkg::MODE_SWINT |=> !pin_oe_o)
        else $error("interrupt-only mode drives pin");
    a_special_no_pin: assert property (
        mode == tcu_pkg::MODE_SPECIAL |=> !pin_oe_o)
        else $error("trigger mode drives pin");
    a_trigger_now: assert property (
        match_evt && mode == tcu_pkg::MODE_SPECIAL |=> adc_start_o)
        else $error("trigger not issued after match");
    a_reset_at_tick: assert property (
        timer_reset_o |-> $past(timer_tick_i) && $past(match_cur))
        else $error("timer reset without tick and match");
    a_once_per_match: assert property (
        !match_evt && !zero_ctrl_wr |=> $stable(pin_out_o))
        else $error("latch changed without new match");
    a_asleep_quiet: assert property (sleep_i |-> !match_evt)
        else $error("match event while sleeping");
    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("bus access not answered in one cycle");

    c_toggle: cover property (match_evt && mode == tcu_pkg::MODE_TOGGLE);
    c_reset: cover property (timer_reset_o);
    c_cancel: cover property (pend_reg && !match_cur && !timer_tick_i);
    c_irq: cover property ($rose(irq_o));

endmodule : tcu_compare

//--- verilog/tcu_pkg.sv
// Purpose: Shared constants and types of the timer compare unit
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes:   Only compare behaviour is covered; capture and PWM are absent
package tcu_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned ADDR_W  = 5;   // Byte address width
    localparam int unsigned DATA_W  = 32;  // Bus data width
    localparam int unsigned REG_W   = 8;   // Register width
    localparam int unsigned CNT_W   = 16;  // Timer and compare width
    localparam int unsigned FLAG_N  = 3;   // Number of sticky events

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [4:0] OFF_CONTROL = 5'h00; // unit_control
    localparam logic [4:0] OFF_CMP_LO  = 5'h04; // compare_value_low
    localparam logic [4:0] OFF_CMP_HI  = 5'h08; // compare_value_high
    localparam logic [4:0] OFF_STATUS  = 5'h0c; // Sticky events, read only
    localparam logic [4:0] OFF_CLEAR   = 5'h10; // Write one to clear
    localparam logic [4:0] OFF_ENABLE  = 5'h14; // Interrupt enables
    localparam logic [4:0] OFF_STATE   = 5'h18; // Live unit state

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int unsigned MODE_LSB    = 0;  // unit_mode_field low bit
    localparam int unsigned FLG_MATCH   = 0;  // unit_irq_flag
    localparam int unsigned FLG_TRIGGER = 1;  // Special trigger fired
    localparam int unsigned FLG_TRESET  = 2;  // Timer reset issued
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [7:0]  CMP_RST     = 8'h00;
    localparam logic [2:0]  ENABLE_RST  = 3'h0;

    // ****************************************
    // Compare modes
    // ****************************************
    typedef enum logic [3:0] {
        MODE_OFF     = 4'b0000, // Unit off
        MODE_TOGGLE  = 4'b0010, // Toggle latch on match
        MODE_SET     = 4'b1000, // Set latch on match
        MODE_CLEAR   = 4'b1001, // Clear latch on match
        MODE_SWINT   = 4'b1010, // Interrupt only
        MODE_SPECIAL = 4'b1011  // Special event trigger
    } tcu_mode_e;

    // ****************************************
    // Bus request carrier
    // ****************************************
    typedef struct packed {
        logic              read;      // Read strobe
        logic              write;     // Write strobe
        logic [4:0]        address;   // Byte address
        logic [3:0]        byteen;    // Byte enables
        logic [31:0]       writedata; // Write data
    } tcu_bus_req_s;

endpackage : tcu_pkg

//--- verilog/tcu_sticky_flag.sv
// Purpose: One sticky event bit with write-one-to-clear
// Assumes: Synchronous active-high reset
// Notes:   A set in the clear cycle wins, so no event is lost
`timescale 1ns/1ns
module tcu_sticky_flag (
    input  wire logic clk_i,    // System clock
    input  wire logic reset_i,  // Synchronous reset
    input  wire logic set_i,    // Event pulse
    input  wire logic clr_i,    // Software clear pulse
    output logic      flag_o    // Sticky flag
);

    // ****************************************
    // Flag register
    // ****************************************
    // Set has priority over clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule : tcu_sticky_flag
